// *** verilog/asr_receiver.v ***
// asynchronous serial receiver with register port
//
// Operation
// - receiver runs only while rx_enable set
// - holding register double-buffers the hidden shifter
// - sample-clock state machine times and levels bits
// - stop bit completes frame, loads holding, sets full
// - error flags appear only at the transfer
// - full at completion: overrun, keep old, drop new
// - no error flags together with overrun
// - status read then data read clears flags
// - receive interrupt whenever full and enabled
// - idle line is ones as long as frame
// - idle detect runs only while rx_enable set, type selectable
// - short detect counts every run of ones
// - long detect counts only after stop bit
// - quiet interrupt when enabled, cleared by sequence
// - quiet flag rearms only after a received frame
// - sleep suppresses flags, cleared by wakeup
// - rouse method zero idle, one address mark
// - idle wakeup clears sleep, next frame normal
// - address mark frame wakes and is received
// - feedback routes transmitter in, output held mark
// - sample clock sixteen times baud, modulus counter
// - ten or eleven bit frames selectable
// - parity bit checked even or odd
//
// Local design decisions: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`include "asr_map.vh"
module asr_receiver #(
  parameter MOD_W = 13               // baud modulus width
) (
  input  wire        ref_clk,
  input  wire        resetn,
  input  wire [1:0]  reg_addr,
  input  wire [15:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [15:0] reg_rdata,
  input  wire        serial_in_pin,
  input  wire        tx_serial,
  output wire        serial_out_pin,
  output wire        rx_irq_req
);
  // engine states
  localparam ST_IDLE  = 2'b00;       // waiting for start edge
  localparam ST_START = 2'b01;       // checking start bit
  localparam ST_DATA  = 2'b10;       // shifting data bits
  localparam ST_STOP  = 2'b11;       // checking stop bit

  reg  [`ASR_C_MSB:0] ctrl;          // control bits, sleep apart
  reg                 rx_sleep;      // receiver asleep
  reg  [MOD_W-1:0]    baud_mod;      // baud modulus
  reg  [1:0]          state;         // engine state
  reg  [3:0]          phase;         // sample clock phase in bit
  reg  [3:0]          bit_cnt;       // data bits taken
  reg  [8:0]          shifter;       // receive shifter
  reg                 samp_a;        // first centre sample
  reg                 samp_b;        // second centre sample
  reg                 noise_acc;     // noise seen in frame
  reg  [3:0]          ones_cnt;      // consecutive one bit-times
  reg                 quiet_armed;   // quiet flag may set again
  reg                 clr_armed;     // status read seen
  reg  [8:0]          rx_holding_reg;
  reg                 rx_full_flag;
  reg                 overrun_flag;
  reg                 noise_flag;
  reg                 framing_error_flag;
  reg                 parity_error_flag;
  reg                 line_quiet_flag;
  reg  [15:0]         stat_word;     // status read value
  reg  [15:0]         ctrl_word;     // control read value

  wire                pin_sync;      // synchronised serial pin
  wire                tick;          // sample clock tick
  wire                rx_line;       // selected receive line

  // named control fields
  wire rx_enable         = ctrl[`ASR_C_RX_EN];
  wire word_length_sel   = ctrl[`ASR_C_WORD_LEN];
  wire parity_on         = ctrl[`ASR_C_PAR_ON];
  wire parity_odd_sel    = ctrl[`ASR_C_PAR_ODD];
  wire quiet_type_sel    = ctrl[`ASR_C_QUIET_TY];
  wire rouse_method_sel  = ctrl[`ASR_C_ROUSE];
  wire internal_feedback = ctrl[`ASR_C_FEEDBACK];
  wire rx_irq_en         = ctrl[`ASR_C_RX_IE];
  wire quiet_irq_en      = ctrl[`ASR_C_QUIET_IE];

  // pin passes two flip-flops before use
  asr_sync #(
    .W       (1)
  ) u_sync (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .d       (serial_in_pin),
    .q       (pin_sync)
  );

  // sample tick at sixteen times the baud rate
  asr_divider #(
    .MOD_W   (MOD_W)
  ) u_div (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .modulus (baud_mod),
    .tick    (tick)
  );

  // loopback: transmitter feeds receiver, pin held at mark
  assign rx_line        = internal_feedback ? tx_serial : pin_sync;
  assign serial_out_pin = internal_feedback ? 1'b1 : tx_serial;

  // register strobes
  wire wr_ctrl = reg_wr & (reg_addr == `ASR_OFS_CTRL);
  wire wr_baud = reg_wr & (reg_addr == `ASR_OFS_BAUD);
  wire rd_stat = reg_rd & (reg_addr == `ASR_OFS_STAT);
  wire rd_data = reg_rd & (reg_addr == `ASR_OFS_DATA);
  wire flag_clr = rd_data & clr_armed;

  // majority vote and noise on the third sample
  wire at_s3   = tick & (phase == `ASR_PH_S3);
  wire maj     = (samp_a & samp_b) | (samp_a & rx_line) |
                 (samp_b & rx_line);
  wire noisy   = ~((samp_a == samp_b) & (samp_b == rx_line));
  wire bit_done = at_s3 & (state != ST_IDLE);

  // frame geometry from word length
  wire [3:0] last_bit   = word_length_sel ? `ASR_LAST_LONG :
                                            `ASR_LAST_SHORT;
  wire [3:0] frame_size = word_length_sel ? `ASR_FRAME_LONG :
                                            `ASR_FRAME_SHORT;

  // shifter aligned to data; msb is always the top shifter bit
  wire [8:0] rx_word = word_length_sel ? shifter :
                                         {1'b0, shifter[8:1]};
  wire       rx_msb  = shifter[8];

  // parity over data and parity bit; even wants zero
  wire par_bad = parity_on & ((^rx_word) ^ parity_odd_sel);

  // frame completion at the stop bit centre
  wire frame_done = bit_done & (state == ST_STOP);
  wire stop_bad   = ~maj;
  wire wake_addr  = frame_done & rx_sleep & rouse_method_sel &
                    rx_msb;
  wire accept     = frame_done & (~rx_sleep | wake_addr);
  wire do_xfer    = accept & ~rx_full_flag;
  wire do_ovr     = accept & rx_full_flag;

  // one bit-time of ones: idle centres always, frame bits if short
  wire idle_one  = at_s3 & (state == ST_IDLE) & rx_line;
  wire frame_one = bit_done & maj & (state != ST_START) &
                   ~quiet_type_sel;
  wire one_bit   = rx_enable & (idle_one | frame_one);
  wire zero_bit  = bit_done & ~maj;
  wire quiet_hit = one_bit & (ones_cnt == frame_size - 4'h1);
  wire wake_idle = quiet_hit & rx_sleep & ~rouse_method_sel;
  wire quiet_set = quiet_hit & quiet_armed & ~rx_sleep;

  // interrupt requests from the flags
  assign rx_irq_req = (rx_irq_en & rx_full_flag) |
                      (quiet_irq_en & line_quiet_flag);

  // bit processor driven by the sample tick
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state     <= ST_IDLE;
      phase     <= 4'h0;
      bit_cnt   <= 4'h0;
      shifter   <= 9'h000;
      samp_a    <= 1'b1;
      samp_b    <= 1'b1;
      noise_acc <= 1'b0;
    end else if (!rx_enable) begin
      state     <= ST_IDLE;
      phase     <= 4'h0;
      bit_cnt   <= 4'h0;
      noise_acc <= 1'b0;
    end else if (tick) begin
      phase <= phase + 4'h1;
      // first two centre samples
      if (phase == `ASR_PH_S1) begin
        samp_a <= rx_line;
      end
      if (phase == `ASR_PH_S2) begin
        samp_b <= rx_line;
      end
      case (state)
        ST_IDLE: begin
          // a low line starts a frame; resync phase to it
          if (!rx_line) begin
            state <= ST_START;
            phase <= 4'h1;
          end
        end
        ST_START: begin
          if (phase == `ASR_PH_S3) begin
            // high majority is a false start
            if (maj) begin
              state <= ST_IDLE;
            end else begin
              state     <= ST_DATA;
              bit_cnt   <= 4'h0;
              noise_acc <= noisy;
            end
          end
        end
        ST_DATA: begin
          if (phase == `ASR_PH_S3) begin
            // lsb first into the top of the shifter
            shifter   <= {maj, shifter[8:1]};
            noise_acc <= noise_acc | noisy;
            bit_cnt   <= bit_cnt + 4'h1;
            if (bit_cnt == last_bit) begin
              state <= ST_STOP;
            end
          end
        end
        ST_STOP: begin
          // frame ends at the stop bit centre
          if (phase == `ASR_PH_S3) begin
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // consecutive ones counter, saturating at the frame size
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ones_cnt <= 4'h0;
    end else if (!rx_enable || zero_bit) begin
      ones_cnt <= 4'h0;
    end else if (one_bit && (ones_cnt != frame_size)) begin
      ones_cnt <= ones_cnt + 4'h1;
    end
  end

  // holding register loads only on an accepted transfer
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rx_holding_reg <= 9'h000;
    end else if (do_xfer) begin
      rx_holding_reg <= rx_word;
    end
  end

  // status flags: hardware set wins over the clearing read
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rx_full_flag       <= 1'b0;
      overrun_flag       <= 1'b0;
      noise_flag         <= 1'b0;
      framing_error_flag <= 1'b0;
      parity_error_flag  <= 1'b0;
      line_quiet_flag    <= 1'b0;
    end else begin
      rx_full_flag <= do_xfer | (rx_full_flag & ~flag_clr);
      overrun_flag <= do_ovr | (overrun_flag & ~flag_clr);
      // error flags follow the transfer only, never overrun
      noise_flag <= (do_xfer & (noise_acc | noisy)) |
                    (noise_flag & ~flag_clr);
      framing_error_flag <= (do_xfer & stop_bad) |
                            (framing_error_flag & ~flag_clr);
      parity_error_flag  <= (do_xfer & par_bad) |
                            (parity_error_flag & ~flag_clr);
      line_quiet_flag    <= quiet_set |
                            (line_quiet_flag & ~flag_clr);
    end
  end

  // quiet flag rearms when a frame reaches the holding register
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      quiet_armed <= 1'b1;
    end else if (do_xfer) begin
      quiet_armed <= 1'b1;
    end else if (quiet_set) begin
      quiet_armed <= 1'b0;
    end
  end

  // clear mechanism: armed by status read, used by data read
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      clr_armed <= 1'b0;
    end else if (rd_stat) begin
      clr_armed <= 1'b1;
    end else if (rd_data) begin
      clr_armed <= 1'b0;
    end
  end

  // control and baud registers
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl     <= `ASR_CTRL_RST;
      baud_mod <= `ASR_BAUD_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl <= reg_wdata[`ASR_C_MSB:0];
      end
      if (wr_baud) begin
        baud_mod <= reg_wdata[MOD_W-1:0];
      end
    end
  end

  // sleep: software write wins, else hardware wakeup clears
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rx_sleep <= 1'b0;
    end else if (wr_ctrl) begin
      rx_sleep <= reg_wdata[`ASR_C_SLEEP];
    end else if (wake_idle || wake_addr) begin
      rx_sleep <= 1'b0;
    end
  end

  // read values for status and control
  always @* begin
    stat_word = 16'h0000;
    stat_word[`ASR_S_FULL]    = rx_full_flag;
    stat_word[`ASR_S_OVERRUN] = overrun_flag;
    stat_word[`ASR_S_NOISE]   = noise_flag;
    stat_word[`ASR_S_FRAMING] = framing_error_flag;
    stat_word[`ASR_S_PARITY]  = parity_error_flag;
    stat_word[`ASR_S_QUIET]   = line_quiet_flag;
    ctrl_word = 16'h0000;
    ctrl_word[`ASR_C_MSB:0]   = ctrl;
    ctrl_word[`ASR_C_SLEEP]   = rx_sleep;
  end

  // read data stand only in the cycle after the strobe
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      case (reg_addr)
        `ASR_OFS_CTRL: begin
          reg_rdata <= ctrl_word;
        end
        `ASR_OFS_STAT: begin
          reg_rdata <= stat_word;
        end
        `ASR_OFS_DATA: begin
          reg_rdata <= {7'h00, rx_holding_reg};
        end
        `ASR_OFS_BAUD: begin
          reg_rdata <= {{(16-MOD_W){1'b0}}, baud_mod};
        end
        default: begin
          reg_rdata <= 16'h0000;
        end
      endcase
    end else begin
      reg_rdata <= 16'h0000;
    end
  end
endmodule // asr_receiver

// *** verilog/asr_map.vh ***
// register offsets, field positions, reset values and timing counts
`ifndef ASR_MAP_VH
`define ASR_MAP_VH
// register word offsets
`define ASR_OFS_CTRL    2'h0
`define ASR_OFS_STAT    2'h1
`define ASR_OFS_DATA    2'h2
`define ASR_OFS_BAUD    2'h3
// serial_control_reg_one field positions
`define ASR_C_RX_EN     0
`define ASR_C_WORD_LEN  1
`define ASR_C_PAR_ON    2
`define ASR_C_PAR_ODD   3
`define ASR_C_QUIET_TY  4
`define ASR_C_SLEEP     5
`define ASR_C_ROUSE     6
`define ASR_C_FEEDBACK  7
`define ASR_C_RX_IE     8
`define ASR_C_QUIET_IE  9
`define ASR_C_MSB       9
// serial_status_reg field positions
`define ASR_S_FULL      0
`define ASR_S_OVERRUN   1
`define ASR_S_NOISE     2
`define ASR_S_FRAMING   3
`define ASR_S_PARITY    4
`define ASR_S_QUIET     5
// reset values
`define ASR_CTRL_RST    10'h000
`define ASR_BAUD_RST    13'h0000
// sample clock phases: three samples near the bit centre
`define ASR_PH_S1       4'h7
`define ASR_PH_S2       4'h8
`define ASR_PH_S3       4'h9
// frame sizes in bit-times, and last data bit index
`define ASR_FRAME_SHORT 4'hA
`define ASR_FRAME_LONG  4'hB
`define ASR_LAST_SHORT  4'h7
`define ASR_LAST_LONG   4'h8
`endif

// *** verilog/asr_sync.v ***
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module asr_sync #(
  parameter W = 1                    // number of bits
) (
  input  wire         ref_clk,
  input  wire         resetn,
  input  wire [W-1:0] d,
  output reg  [W-1:0] q
);
  reg [W-1:0] meta;                  // first stage, read only by q

  // two stages; idle serial level is one
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      meta <= {W{1'b1}};
      q    <= {W{1'b1}};
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule // asr_sync

// *** verilog/asr_divider.v ***
// modulus counter making the sixteen-times sample tick
`timescale 1ns/1ps
module asr_divider #(
  parameter MOD_W = 13               // modulus width
) (
  input  wire             ref_clk,
  input  wire             resetn,
  input  wire [MOD_W-1:0] modulus,
  output reg              tick
);
  reg  [MOD_W:0] cnt;                // cycle counter
  wire [MOD_W:0] last;               // last count of a period

  // period is twice the modulus: 16x baud of clk/(32*mod)
  assign last = {modulus, 1'b0} - {{MOD_W{1'b0}}, 1'b1};

  // zero modulus stops the tick
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cnt  <= {(MOD_W+1){1'b0}};
      tick <= 1'b0;
    end else if (modulus == {MOD_W{1'b0}}) begin
      cnt  <= {(MOD_W+1){1'b0}};
      tick <= 1'b0;
    end else if (cnt >= last) begin
      cnt  <= {(MOD_W+1){1'b0}};
      tick <= 1'b1;
    end else begin
      cnt  <= cnt + {{MOD_W{1'b0}}, 1'b1};
      tick <= 1'b0;
    end
  end
endmodule // asr_divider

// *** tb/asr_line_model.sv ***
// remote sender model driving frames onto the idle-high line
`timescale 1ns/1ps
module asr_line_model #(
  parameter BIT = 32                 // cycles per bit-time
) (
  input  wire        ref_clk,
  input  wire        go,
  input  wire [11:0] frame,
  input  wire [3:0]  len,
  input  wire        glitch,
  output wire        line,
  output reg         busy
);
  reg [11:0] sh;                     // bits still to send
  reg [3:0]  left;                   // bits remaining
  reg [7:0]  cnt;                    // cycles left in bit
  reg        lvl;                    // driven level
  // two-cycle upset in first data bit, hits one sample
  assign line = lvl ^ (glitch && busy && left == len - 4'h2 &&
                       cnt >= BIT - 18 && cnt <= BIT - 17);
  initial begin
    lvl = 1'b1;
    busy = 1'b0;
  end
  // lsb first, one bit-time each, back to mark after
  always @(posedge ref_clk) begin
    if (go && !busy) begin
      lvl  <= frame[0];
      sh   <= frame >> 1;
      left <= len - 4'h1;
      cnt  <= BIT - 1;
      busy <= 1'b1;
    end else if (busy && cnt != 0) begin
      cnt <= cnt - 8'h01;
    end else if (busy && left != 0) begin
      lvl  <= sh[0];
      sh   <= sh >> 1;
      left <= left - 4'h1;
      cnt  <= BIT - 1;
    end else begin
      lvl  <= 1'b1;
      busy <= 1'b0;
    end
  end
endmodule // asr_line_model

// *** tb/asr_receiver_assertions.sv ***
// port checker for the serial receiver
`timescale 1ns/1ps
module asr_receiver_chk (
  input wire        ref_clk,
  input wire        resetn,
  input wire [1:0]  reg_addr,
  input wire [15:0] reg_wdata,
  input wire        reg_wr,
  input wire        reg_rd,
  input wire [15:0] reg_rdata,
  input wire        serial_in_pin,
  input wire        tx_serial,
  input wire        serial_out_pin,
  input wire        rx_irq_req
);
  reg [9:0] sh;                      // control shadow
  // follow control writes
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) sh <= 10'h000;
    else if (reg_wr && reg_addr == 2'h0) sh <= reg_wdata[9:0];
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  property p_rd_idle;
    !$past(reg_rd) |-> reg_rdata == 16'h0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data not idle");
  property p_loop_mark;
    sh[7] |-> serial_out_pin;
  endproperty
  a_loop_mark: assert property (p_loop_mark)
    else $error("pin not mark in feedback");
  property p_loop_pass;
    !sh[7] |-> serial_out_pin == tx_serial;
  endproperty
  a_loop_pass: assert property (p_loop_pass)
    else $error("pin not following transmitter");
  property p_irq_off;
    !sh[8] && !sh[9] |-> !rx_irq_req;
  endproperty
  a_irq_off: assert property (p_irq_off)
    else $error("request while disabled");
  property p_irq_stat;
    reg_rd && reg_addr == 2'h1 |=> $past(rx_irq_req) ==
      (($past(sh[8]) && reg_rdata[0]) || ($past(sh[9]) && reg_rdata[5]));
  endproperty
  a_irq_stat: assert property (p_irq_stat)
    else $error("request not matching flags");
  property p_irq_fall;
    $fell(rx_irq_req) |-> $past(reg_rd && reg_addr == 2'h2) ||
      $past(reg_wr && reg_addr == 2'h0);
  endproperty
  a_irq_fall: assert property (p_irq_fall)
    else $error("request dropped without clear");
  property p_stat_rsvd;
    reg_rd && reg_addr == 2'h1 |=> reg_rdata[15:6] == 10'h000;
  endproperty
  a_stat_rsvd: assert property (p_stat_rsvd)
    else $error("status spare bits set");
  property p_data_rsvd;
    reg_rd && reg_addr == 2'h2 |=> reg_rdata[15:9] == 7'h00;
  endproperty
  a_data_rsvd: assert property (p_data_rsvd)
    else $error("data spare bits set");
  property p_ctrl_back;
    reg_rd && reg_addr == 2'h0 |=> reg_rdata[15:10] == 6'h00 &&
      {reg_rdata[9:6], reg_rdata[4:0]} == {$past(sh[9:6]), $past(sh[4:0])};
  endproperty
  a_ctrl_back: assert property (p_ctrl_back)
    else $error("control readback wrong");
endmodule // asr_receiver_chk
bind asr_receiver asr_receiver_chk u_chk (.ref_clk(ref_clk),
  .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .serial_in_pin(serial_in_pin), .tx_serial(tx_serial),
  .serial_out_pin(serial_out_pin), .rx_irq_req(rx_irq_req));

// *** tb/test_asr_receiver.sv ***
// self-checking bench for the serial receiver
`timescale 1ns/1ps
module test_asr_receiver;
  localparam BT = 32;                // cycles per bit-time
  reg         ref_clk, resetn;       // clock, reset
  reg  [1:0]  reg_addr;              // register index
  reg  [15:0] reg_wdata, v;          // write data, last read
  reg         reg_wr, reg_rd;        // strobes
  wire [15:0] reg_rdata;             // read data
  wire        rx_line, tx_line;      // far and loop lines
  wire        serial_out_pin;        // transmit pin
  wire        rx_irq_req;            // request
  wire        rx_busy, tx_busy;      // senders busy
  reg  [11:0] frm;                   // frame bits
  reg  [3:0]  len;                   // frame length
  reg         go_rx, go_tx, glt, wl, p;
  integer     bad_count, tests_run, i;
  asr_receiver #(.MOD_W(13)) DUT (.ref_clk(ref_clk), .resetn(resetn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .serial_in_pin(rx_line),
    .tx_serial(tx_line), .serial_out_pin(serial_out_pin),
    .rx_irq_req(rx_irq_req));
  asr_line_model #(.BIT(BT)) rmt (.ref_clk(ref_clk), .go(go_rx),
    .frame(frm), .len(len), .glitch(glt), .line(rx_line), .busy(rx_busy));
  asr_line_model #(.BIT(BT)) loc (.ref_clk(ref_clk), .go(go_tx),
    .frame(frm), .len(len), .glitch(1'b0), .line(tx_line),
    .busy(tx_busy));
  always #12.5 ref_clk = ~ref_clk;
  task conclude;
    begin
      $display("compares %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
    end
  endtask
  task chk(input [15:0] s, input [15:0] e);
    begin
      tests_run = tests_run + 1;
      if (s !== e) begin
        bad_count = bad_count + 1;
        $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
      end
    end
  endtask
  task tick(input integer n);
    repeat (n) @(posedge ref_clk);
  endtask
  // one-cycle write strobe
  task wr(input [1:0] a, input [15:0] d);
    begin
      @(posedge ref_clk);
      reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
    end
  endtask
  // one-cycle read strobe, data in the following cycle
  task rd(input [1:0] a, output [15:0] d);
    begin
      @(posedge ref_clk);
      reg_rd <= 1'b1; reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
    end
  endtask
  task setc(input [15:0] c);
    begin
      wl = c[1];
      wr(2'h0, c);
    end
  endtask
  // queue a frame once both senders are free
  task send(input [8:0] d, input sb, input g, input lp);
    integer k;
    begin
      #1;
      for (k = 0; k < 2000 && (rx_busy || tx_busy); k = k + 1) tick(1);
      if (k == 2000) begin bad_count = bad_count + 1; conclude; end
      @(posedge ref_clk);
      frm <= wl ? {1'b0, sb, d, 1'b0} : {2'b00, sb, d[7:0], 1'b0};
      len <= wl ? 4'hB : 4'hA;
      glt <= g; go_rx <= !lp; go_tx <= lp;
      @(posedge ref_clk);
      go_rx <= 1'b0; go_tx <= 1'b0;
    end
  endtask
  // poll status until the full flag shows
  task wfull;
    integer k;
    begin
      v = 16'h0000;
      for (k = 0; k < 800 && v[0] !== 1'b1; k = k + 1) rd(2'h1, v);
      if (k == 800) begin bad_count = bad_count + 1; conclude; end
    end
  endtask
  task flush;
    begin
      tick(13 * BT); rd(2'h1, v); rd(2'h2, v);
    end
  endtask
  initial begin
    ref_clk = 0; resetn = 0; reg_addr = 0; reg_wdata = 0; reg_wr = 0;
    reg_rd = 0; frm = 0; len = 4'hA; go_rx = 0; go_tx = 0; glt = 0;
    wl = 0; bad_count = 0; tests_run = 0;
    tick(8); resetn <= 1'b1;
    rd(2'h0, v); chk(v, 16'h0000);
    rd(2'h1, v); chk(v, 16'h0000);
    wr(2'h3, 16'h0001);
    rd(2'h3, v); chk(v, 16'h0001);
    send(9'h0A5, 1, 0, 0); tick(12 * BT);
    rd(2'h1, v); chk(v, 16'h0000);
    $display("end reset and disable");
    setc(16'h0001); send(9'h0A5, 1, 0, 0);
    wfull; chk(v, 16'h0001);
    rd(2'h2, v); chk(v, 16'h00A5);
    send(9'h03C, 1, 0, 0); tick(11 * BT);
    rd(2'h2, v); chk(v, 16'h003C);
    rd(2'h1, v); chk(v, 16'h0001);
    rd(2'h2, v); rd(2'h1, v); chk(v, 16'h0000);
    send(9'h011, 1, 0, 0); send(9'h022, 0, 0, 0); tick(12 * BT);
    rd(2'h1, v); chk(v, 16'h0003);
    rd(2'h2, v); chk(v, 16'h0011);
    send(9'h05A, 1, 1, 0); wfull; chk(v, 16'h0005);
    rd(2'h2, v); chk(v, 16'h005A);
    send(9'h00F, 0, 0, 0); wfull; chk(v, 16'h0009);
    rd(2'h2, v);
    $display("end frames and errors");
    for (i = 0; i < 4; i = i + 1) begin
      setc(16'h0007 | {12'h000, i[0], 3'h0});
      p = ^8'h3B ^ i[0] ^ i[1];
      send({p, 8'h3B}, 1, 0, 0);
      wfull; chk(v, {11'h000, i[1], 4'h1});
      rd(2'h2, v); chk(v, {7'h00, p, 8'h3B});
    end
    $display("end parity");
    for (i = 0; i < 2; i = i + 1) begin
      flush; setc(16'h0301 | {11'h000, i[0], 4'h0});
      send(9'h080, 1, 0, 0); wfull;
      chk({15'h0000, rx_irq_req}, 16'h0001);
      rd(2'h2, v); tick(280);
      rd(2'h1, v); chk(v, i ? 16'h0000 : 16'h0020);
      tick(60); rd(2'h1, v); chk(v, 16'h0020);
      chk({15'h0000, rx_irq_req}, 16'h0001);
      // restart the ones count; the cleared flag must stay disarmed
      rd(2'h2, v); setc(16'h0300);
      setc(16'h0301 | {11'h000, i[0], 4'h0}); tick(15 * BT);
      rd(2'h1, v); chk(v, 16'h0000);
    end
    $display("end idle line");
    flush; setc(16'h0061); send(9'h012, 1, 0, 0); tick(11 * BT);
    rd(2'h1, v); chk(v, 16'h0000);
    send(9'h092, 1, 0, 0); wfull; chk(v, 16'h0001);
    rd(2'h2, v); chk(v, 16'h0092);
    rd(2'h0, v); chk(v, 16'h0041);
    flush; setc(16'h0021);
    send(9'h033, 1, 0, 0); send(9'h044, 1, 0, 0); tick(11 * BT);
    rd(2'h1, v); chk(v, 16'h0000);
    rd(2'h0, v); chk(v, 16'h0021);
    tick(12 * BT); rd(2'h0, v); chk(v, 16'h0001);
    send(9'h055, 1, 0, 0); wfull; rd(2'h2, v); chk(v, 16'h0055);
    $display("end wakeup");
    flush; setc(16'h0081); send(9'h0C3, 1, 0, 1);
    wfull; chk(v & 16'h001F, 16'h0001);
    rd(2'h2, v); chk(v, 16'h00C3);
    $display("end feedback");
    conclude;
  end
endmodule // test_asr_receiver
